/* File: common/tmr_pkg.sv */
// package: register map, field layout and constants of the 8-bit timer/counter
// assumes one clock domain and an AXI4-Lite register port with 32-bit data
package tmr_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_MODE   = 8'h00;
   localparam logic [7:0] ADDR_CLKSEL = 8'h04;
   localparam logic [7:0] ADDR_COUNT  = 8'h08;
   localparam logic [7:0] ADDR_RELOAD = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_CLEAR  = 8'h14;
   localparam logic [7:0] ADDR_ENABLE = 8'h18;
   // status, clear and enable bit positions
   localparam int EV_OVF = 0;
   localparam int EV_PIN = 1;
   localparam int EV_W   = 2;
   // reset values
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] COUNT_RST  = 8'h00;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   // counter values and the interrupt vector
   localparam logic [7:0] FULL_SCALE = 8'hFF;
   localparam logic [7:0] ZERO_SCALE = 8'h00;
   localparam logic [7:0] IRQ_VECTOR = 8'h08;
   // pwm overflow boundaries as count masks (256, 64, 32, 16)
   localparam logic [7:0] MASK_256 = 8'hFF;
   localparam logic [7:0] MASK_64  = 8'h3F;
   localparam logic [7:0] MASK_32  = 8'h1F;
   localparam logic [7:0] MASK_16  = 8'h0F;
   // prescaler: width of the tick divider and the top of each divide chain
   localparam int         PRESC_W   = 8;
   localparam logic [3:0] CPU_TOP   = 4'h8;
   localparam logic [3:0] HOSC_TOP  = 4'h7;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // mode register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       run;
      logic [2:0] rate;
      logic       ext;
      logic       aload;
      logic       tone;
      logic       pwm;
   } mode_t;

   // clock select register layout
   typedef struct packed {
      logic fast;
      logic wake;
   } clksel_t;
endpackage

/* File: src/prescaler.sv */
// prescaler: divides the instruction or high-speed tick into the counter tick
// assumes fcpu_tick and fhosc_tick are one-cycle enables synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module prescaler #(
   parameter int W = tmr_pkg::PRESC_W
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       fcpu_tick,
   input  wire logic       fhosc_tick,
   input  wire logic       fast,
   input  wire logic [2:0] rate,
   output var  logic       tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } pre_t;

   pre_t         s_q;
   pre_t         s_d;
   logic         src;
   logic [3:0]   shift;
   logic [W-1:0] mask;

   always_comb
   begin
      s_d   = s_q;
      src   = fast ? fhosc_tick : fcpu_tick;
      shift = fast ? (tmr_pkg::HOSC_TOP - {1'b0, rate}) : (tmr_pkg::CPU_TOP - {1'b0, rate});
      mask  = W'((9'h001 << shift) - 9'h001);
      s_d.tick = src && ((s_q.cnt & mask) == mask);
      if (src)
         s_d.cnt = s_q.cnt + W'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign tick = s_q.tick;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_tick_has_source: assert property (tick |-> $past(fast ? fhosc_tick : fcpu_tick))
      else $error("prescaler tick without a source tick");
endmodule
`default_nettype wire

/* File: src/event_sync.sv */
// event_sync: brings the event pin into aclk and marks each rising edge once
// assumes the pin pulses are wider than two aclk periods
`timescale 1ns/10ps
`default_nettype none
module event_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   output var  logic rise
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic rise;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   always_comb
   begin
      s_d      = s_q;
      s_d.meta = pin;
      s_d.sync = s_q.meta;
      s_d.last = s_q.sync;
      s_d.rise = s_q.sync && !s_q.last;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign rise = s_q.rise;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_single_edge: assert property (rise |=> !rise)
      else $error("event edge reported twice");
endmodule
`default_nettype wire

/* File: src/timer_counter.sv */
// timer_counter: 8-bit up timer/event counter with pwm, buzzer and wake-up
// assumes AXI4-Lite master on aclk; fcpu/fhosc ticks are aclk enables
//
// Overview of operation
// - the count is an 8-bit up counter stepping once per selected clock
// - the run bit at zero holds the count; at one it counts
// - overflow is the step off the top count: 0xFF, or 0x3F, 0x1F or 0x0F for the shorter pwm periods
// - each overflow sets the overflow flag until software clears it
// - reload writes while running wait in a buffer until next overflow
// - auto-reload bit picks reload in timer modes; pwm always restarts from zero
// - enabled overflow raises the interrupt pointing the core at address 8
// - external source counts pin pulses and ignores prescaler and fast bit
// - slow source is instruction clock divided by 256 down to 2
// - fast source is high-speed clock divided by 128 down to 1
// - buzzer output toggles at each overflow, half the overflow rate
// - all functions keep running in green mode
// - wake enable makes a green-mode overflow wake the system
// - in pwm the auto-reload and tone bits pick 256, 64, 32 or 16
// - in event mode the pin interrupt flag stays zero
`timescale 1ns/10ps
`default_nettype none
module timer_counter (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        fcpu_tick,
   input  wire logic        fhosc_tick,
   input  wire logic        event_input_pin,
   input  wire logic        idle_mode,
   output var  logic        irq,
   output var  logic [7:0]  irq_vector,
   output var  logic        wave_out,
   output var  logic        wake_req
);
   typedef struct packed {
      tmr_pkg::mode_t             mode;
      tmr_pkg::clksel_t           clk;
      logic [7:0]                 count_value;
      logic [7:0]                 reload_buf;
      logic [7:0]                 reload_value;
      logic [tmr_pkg::EV_W-1:0]   status;
      logic [tmr_pkg::EV_W-1:0]   enable;
      logic                       buzz;
      logic                       wave;
      logic                       irq;
      logic [7:0]                 vector;
      logic                       wake;
      logic                       aw_have;
      logic [7:0]                 aw_addr;
      logic                       w_have;
      logic [7:0]                 w_data;
      logic                       w_lane0;
      logic                       awready;
      logic                       wready;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       arready;
      logic                       rvalid;
      logic [31:0]                rdata;
      logic [1:0]                 rresp;
   } st_t;

   st_t        s_q;
   st_t        s_d;
   logic       pre_tick;
   logic       ev_rise;
   logic       do_wr;
   logic       wr_count;
   logic       cnt_tick;
   logic       pwm_on;
   logic       ovf;
   logic [7:0] mask;
   logic       hit;
   logic [7:0] rd_byte;

   prescaler #(
      .W (tmr_pkg::PRESC_W)
   ) u_pre (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .fcpu_tick  (fcpu_tick),
      .fhosc_tick (fhosc_tick),
      .fast       (s_q.clk.fast),
      .rate       (s_q.mode.rate),
      .tick       (pre_tick)
   );

   event_sync u_evt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (event_input_pin),
      .rise    (ev_rise)
   );

   always_comb
   begin
      s_d      = s_q;
      hit      = 1'b1;
      rd_byte  = 8'h00;
      // write channels are taken in either order and held until both are in
      if (s_q.awready && s_axi_awvalid)
      begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_q.wready && s_axi_wvalid)
      begin
         s_d.w_have  = 1'b1;
         s_d.w_data  = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;
      do_wr    = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      wr_count = do_wr && s_q.w_lane0 && (s_q.aw_addr == tmr_pkg::ADDR_COUNT);

      cnt_tick = s_q.mode.run && (s_q.mode.ext ? ev_rise : pre_tick);
      pwm_on   = s_q.mode.pwm && !s_q.mode.ext;
      // pwm boundary from the two bits
      unique case ({pwm_on, s_q.mode.aload, s_q.mode.tone})
         3'b101:  mask = tmr_pkg::MASK_64;
         3'b110:  mask = tmr_pkg::MASK_32;
         3'b111:  mask = tmr_pkg::MASK_16;
         default: mask = tmr_pkg::MASK_256;
      endcase
      ovf = cnt_tick && ((s_q.count_value & mask) == mask);

      // idle_mode gates nothing here, the timer runs on in green mode
      if (ovf)
      begin
         // buffered value becomes active here, or at once on a reload write while stopped
         s_d.reload_value = s_q.reload_buf;
         if (!pwm_on && s_q.mode.aload)
            s_d.count_value = s_q.reload_buf;
         else
            s_d.count_value = tmr_pkg::ZERO_SCALE;
         if (s_q.mode.tone && !pwm_on)
            s_d.buzz = !s_q.buzz;
      end
      else if (cnt_tick)
         s_d.count_value = s_q.count_value + 8'h01;

      // register writes; only byte lane 0 carries data
      if (do_wr)
      begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = tmr_pkg::RESP_OKAY;
         if (s_q.w_lane0)
         begin
            unique case (s_q.aw_addr)
               tmr_pkg::ADDR_MODE:   s_d.mode = s_q.w_data;
               tmr_pkg::ADDR_CLKSEL: s_d.clk = s_q.w_data[2:1];
               tmr_pkg::ADDR_COUNT:  s_d.count_value = s_q.w_data;
               tmr_pkg::ADDR_RELOAD:
               begin
                  s_d.reload_buf = s_q.w_data;
                  // while stopped both buffers take the value
                  if (!s_q.mode.run)
                     s_d.reload_value = s_q.w_data;
               end
               tmr_pkg::ADDR_CLEAR:  s_d.status = s_q.status & ~s_q.w_data[tmr_pkg::EV_W-1:0];
               tmr_pkg::ADDR_ENABLE: s_d.enable = s_q.w_data[tmr_pkg::EV_W-1:0];
               tmr_pkg::ADDR_STATUS: s_d.bresp = tmr_pkg::RESP_OKAY;
               default:              s_d.bresp = tmr_pkg::RESP_SLVERR;
            endcase
         end
      end

      // hardware set wins over a clear in the same cycle
      if (ovf)
         s_d.status[tmr_pkg::EV_OVF] = 1'b1;
      if (ev_rise)
         s_d.status[tmr_pkg::EV_PIN] = 1'b1;
      // pin flag held at zero in event mode
      if (s_d.mode.ext)
         s_d.status[tmr_pkg::EV_PIN] = 1'b0;

      // pwm: count below the active reload value drives the pin high
      if (!s_d.mode.run)
         s_d.wave = 1'b0;
      else if (s_d.mode.pwm && !s_d.mode.ext)
         s_d.wave = (s_d.count_value & mask) < (s_d.reload_value & mask);
      else
         s_d.wave = s_d.mode.tone && s_d.buzz;

      s_d.irq    = |(s_d.status & s_d.enable);
      s_d.vector = s_d.irq ? tmr_pkg::IRQ_VECTOR : 8'h00;
      s_d.wake   = ovf && idle_mode && s_q.clk.wake;

      // read channel: one read in flight, answered the cycle after it is taken
      if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;
      unique case (s_axi_araddr)
         tmr_pkg::ADDR_MODE:   rd_byte = s_q.mode;
         tmr_pkg::ADDR_CLKSEL: rd_byte = {5'h00, s_q.clk, 1'b0};
         tmr_pkg::ADDR_COUNT:  rd_byte = s_q.count_value;
         tmr_pkg::ADDR_STATUS: rd_byte = {6'h00, s_q.status};
         tmr_pkg::ADDR_ENABLE: rd_byte = {6'h00, s_q.enable};
         tmr_pkg::ADDR_RELOAD: rd_byte = 8'h00;
         tmr_pkg::ADDR_CLEAR:  rd_byte = 8'h00;
         default:              hit = 1'b0;
      endcase
      if (s_q.arready && s_axi_arvalid)
      begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = {24'h000000, rd_byte};
         s_d.rresp  = hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end

      s_d.awready = !s_d.aw_have;
      s_d.wready  = !s_d.w_have;
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q              <= '0;
         s_q.mode         <= tmr_pkg::MODE_RST;
         s_q.count_value  <= tmr_pkg::COUNT_RST;
         s_q.reload_buf   <= tmr_pkg::RELOAD_RST;
         s_q.reload_value <= tmr_pkg::RELOAD_RST;
      end
      else
         s_q <= s_d;
   end

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign irq           = s_q.irq;
   assign irq_vector    = s_q.vector;
   assign wave_out      = s_q.wave;
   assign wake_req      = s_q.wake;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence overflow_plain;
      ovf && !wr_count && !pwm_on && !s_q.mode.aload;
   endsequence
   sequence overflow_reload;
      ovf && !wr_count && !pwm_on && s_q.mode.aload;
   endsequence
   sequence stopped_no_write;
      !s_q.mode.run && !wr_count;
   endsequence

   chk_stop_hold: assert property (stopped_no_write |=> $stable(s_q.count_value))
      else $error("count moved while stopped");
   chk_wrap_zero: assert property (overflow_plain |=> s_q.count_value == 8'h00)
      else $error("overflow did not wrap to zero");
   chk_ovf_flag: assert property (ovf |=> s_q.status[0] [*1] ##1 1'b1)
      else $error("overflow flag not set");
   chk_reload_copy: assert property (overflow_reload |=> s_q.count_value == $past(s_q.reload_buf))
      else $error("reload value not taken at overflow");
   chk_irq_vector: assert property (s_q.status[0] && s_q.enable[0] |-> irq && irq_vector == 8'h08)
      else $error("enabled overflow without interrupt");
   chk_ext_ignore: assert property (s_q.mode.run && s_q.mode.ext && !ev_rise && !wr_count |=> $stable(s_q.count_value))
      else $error("event counter moved without a pin edge");
   chk_buzz_toggle: assert property (ovf && s_q.mode.tone && !pwm_on |=> s_q.buzz != $past(s_q.buzz))
      else $error("buzzer did not toggle");
   chk_wake_req: assert property (ovf && idle_mode && s_q.clk.wake |=> wake_req)
      else $error("green mode overflow did not wake");
   chk_pin_quiet: assert property (s_q.mode.ext |-> !s_q.status[1])
      else $error("pin flag set in event mode");
endmodule
`default_nettype wire

/* File: sim/pulse_src.sv */
// pulse_src: far-side stand-in giving clock ticks and an event pulse train
// assumes aclk is the bench clock; pulses start on a one-cycle start strobe
`timescale 1ns/10ps
`default_nettype none
module pulse_src (
   input  wire logic       aclk,
   input  wire logic       start,
   input  wire logic [7:0] n_req,
   output var  logic       pin,
   output var  logic       busy,
   output var  logic       fcpu_tick,
   output var  logic       fhosc_tick
);
   logic [1:0] div_q;

   initial
   begin
      pin = 1'b0;
      busy = 1'b0;
      div_q = 2'h0;
      fcpu_tick = 1'b0;
      fhosc_tick = 1'b0;
   end

   // instruction clock at a quarter of the oscillator, as a slow core would run
   always @(posedge aclk)
   begin
      div_q <= div_q + 2'h1;
      fhosc_tick <= 1'b1;
      fcpu_tick <= (div_q == 2'h3);
   end

   // three cycles high and low: wider than the synchroniser needs
   always @(posedge aclk)
   begin
      if (start && !busy)
      begin
         busy <= 1'b1;
         for (int i = 0; i < n_req; i++)
         begin
            pin <= 1'b1;
            repeat (3) @(posedge aclk);
            pin <= 1'b0;
            repeat (3) @(posedge aclk);
         end
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: sim/eight_bit_timer_counter_pwm_buzzer_tb.sv */
// testbench: drives the timer over AXI4-Lite and checks counts, flags, waves
// assumes pulse_src supplies the ticks and the event pin
`timescale 1ns/10ps
`default_nettype none
module eight_bit_timer_counter_pwm_buzzer_tb;
   logic        aclk, aresetn, start, busy, pin, fcpu_tick, fhosc_tick;
   logic        idle_mode, irq, wave_out, wake_req;
   logic [7:0]  irq_vector, n_req, s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          bad_count, checks, cyc, t0, t1, t2, n;

   timer_counter dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fcpu_tick, .fhosc_tick,
      .event_input_pin(pin), .idle_mode, .irq, .irq_vector, .wave_out, .wake_req);
   pulse_src src_u (.aclk, .start, .n_req, .pin, .busy, .fcpu_tick, .fhosc_tick);

   always #25 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;

   task automatic end_sim;
      if (bad_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang;
      bad_count++;
      $display("ERROR %0t: wait ran out", $time);
      end_sim;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int k;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (k == 100) hang;
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (k == 100) hang;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // configuration settles with run low before run is raised
   task automatic go(input tmr_pkg::mode_t m);
      wr(tmr_pkg::ADDR_MODE, {1'b0, m[6:0]});
      wr(tmr_pkg::ADDR_MODE, m);
   endtask

   task automatic wait_lvl(input logic v);
      int k;
      for (k = 0; k < 600; k++)
      begin
         @(posedge aclk);
         if (wave_out === v) break;
      end
      if (k == 600) hang;
   endtask

   task automatic pulses(input logic [7:0] cnt);
      int k;
      n_req <= cnt;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      @(posedge aclk);
      for (k = 0; k < 2000 && busy; k++) @(posedge aclk);
      if (k == 2000) hang;
      repeat (8) @(posedge aclk);
   endtask

   // aclk cycles per counter step for each clock source and prescale code
   function automatic int div_cyc(input int fast, input int code);
      return fast ? (1 << (7 - code)) : (4 << (8 - code));
   endfunction

   function automatic logic in_span(input logic [7:0] v, input int t, input int d);
      return (v >= t / d) && (v <= (t + 10) / d + 1);
   endfunction

   function automatic int pwm_len(input int k);
      return (k == 0) ? 256 : (k == 1) ? 64 : (k == 2) ? 32 : 16;
   endfunction

   initial
   begin
      {aclk, aresetn, start, n_req, idle_mode, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(63067));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int a = 0; a < 7; a++)
      begin
         rd_reg(8'(a * 4));
         chk(rd, 32'h00000000);
      end
      rd_reg(8'h1C);
      chk(rd, 32'h00000000);
      chk(rsp, tmr_pkg::RESP_SLVERR);
      n = $urandom % 256;
      wr(tmr_pkg::ADDR_COUNT, 8'(n));
      rd_reg(tmr_pkg::ADDR_COUNT);
      chk(rd, 32'(n));
      // lane 0 strobe low: answered OKAY, count untouched
      s_axi_wstrb <= 4'hE;
      wr(tmr_pkg::ADDR_COUNT, 8'(n) ^ 8'hFF);
      s_axi_wstrb <= 4'hF;
      chk(rsp, tmr_pkg::RESP_OKAY);
      wr(8'h1C, 8'h01);
      chk(rsp, tmr_pkg::RESP_SLVERR);
      rd_reg(tmr_pkg::ADDR_COUNT);
      chk(rd, 32'(n));
      // step rate of both sources over every prescale code
      for (int f = 0; f < 2; f++)
         for (int c = 0; c < 8; c++)
         begin
            wr(tmr_pkg::ADDR_CLKSEL, 8'(f << 2));
            wr(tmr_pkg::ADDR_COUNT, 8'h00);
            go('{1'b1, 3'(c), 1'b0, 1'b0, 1'b0, 1'b0});
            repeat (240) @(posedge aclk);
            wr(tmr_pkg::ADDR_MODE, 8'h00);
            rd_reg(tmr_pkg::ADDR_COUNT);
            chk(in_span(rd[7:0], 240, div_cyc(f, c)), 1'b1);
            n = rd;
            repeat (20) @(posedge aclk);
            rd_reg(tmr_pkg::ADDR_COUNT);
            chk(rd, 32'(n));
         end
      // overflow flag, masking, vector and clearing
      wr(tmr_pkg::ADDR_COUNT, 8'hF8);
      wr(tmr_pkg::ADDR_RELOAD, 8'hF8);
      go('{1'b1, 3'h7, 1'b0, 1'b1, 1'b0, 1'b0});
      repeat (30) @(posedge aclk);
      rd_reg(tmr_pkg::ADDR_STATUS);
      chk({rd[0], irq}, 2'b10);
      wr(tmr_pkg::ADDR_ENABLE, 8'h01);
      chk({irq, irq_vector}, {1'b1, tmr_pkg::IRQ_VECTOR});
      wr(tmr_pkg::ADDR_MODE, 8'h00);
      rd_reg(tmr_pkg::ADDR_COUNT);
      chk(rd[7:0] >= 8'hF8, 1'b1);
      repeat (20) @(posedge aclk);
      chk(irq, 1'b1);
      wr(tmr_pkg::ADDR_CLEAR, 8'h01);
      rd_reg(tmr_pkg::ADDR_STATUS);
      chk({rd[0], irq, irq_vector}, 10'h000);
      // event counting ignores the oscillator and hides the pin flag
      pulses(8'h01);
      rd_reg(tmr_pkg::ADDR_STATUS);
      chk(rd[1], 1'b1);
      wr(tmr_pkg::ADDR_CLEAR, 8'h02);
      wr(tmr_pkg::ADDR_COUNT, 8'h00);
      go('{1'b1, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0});
      n = 1 + $urandom % 40;
      pulses(8'(n));
      rd_reg(tmr_pkg::ADDR_COUNT);
      chk(rd, 32'(n));
      rd_reg(tmr_pkg::ADDR_STATUS);
      chk(rd[1], 1'b0);
      // every pwm boundary, duty from the reload value
      for (int k = 0; k < 4; k++)
      begin
         wr(tmr_pkg::ADDR_MODE, 8'h00);
         wr(tmr_pkg::ADDR_RELOAD, 8'(5 + k));
         wr(tmr_pkg::ADDR_COUNT, 8'h00);
         go('{1'b1, 3'h7, 1'b0, k[1], k[0], 1'b1});
         wait_lvl(1'b0);
         wait_lvl(1'b1);
         t0 = cyc;
         wait_lvl(1'b0);
         t1 = cyc;
         wait_lvl(1'b1);
         t2 = cyc;
         chk(t1 - t0, 5 + k);
         chk(t2 - t0, pwm_len(k));
      end
      // buzzer halves the overflow rate; a new reload waits for overflow
      wr(tmr_pkg::ADDR_MODE, 8'h00);
      wr(tmr_pkg::ADDR_COUNT, 8'hF0);
      wr(tmr_pkg::ADDR_RELOAD, 8'hF0);
      go('{1'b1, 3'h7, 1'b0, 1'b1, 1'b1, 1'b0});
      wait_lvl(!wave_out);
      t0 = cyc;
      wr(tmr_pkg::ADDR_RELOAD, 8'hE0);
      wait_lvl(!wave_out);
      t1 = cyc;
      wait_lvl(!wave_out);
      t2 = cyc;
      chk(t1 - t0, 16);
      chk(t2 - t1, 32);
      // an overflow outside green mode, with the wake enable bit still clear, must not wake
      for (n = 0; n < 40 && wake_req !== 1'b1; n++) @(posedge aclk);
      chk(n, 40);
      idle_mode <= 1'b1;
      wr(tmr_pkg::ADDR_CLKSEL, 8'h06);
      for (n = 0; n < 100 && wake_req !== 1'b1; n++) @(posedge aclk);
      chk(n < 100, 1'b1);
      // flag cleared first so only a green-mode overflow can set it
      wr(tmr_pkg::ADDR_CLEAR, 8'h01);
      wait_lvl(!wave_out);
      rd_reg(tmr_pkg::ADDR_STATUS);
      chk(rd[0], 1'b1);
      idle_mode <= 1'b0;
      end_sim;
   end
endmodule
`default_nettype wire
